// ===== core/cmp_branch_pkg.sv
package cmp_branch_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int PC_W = 16;
    localparam int OFS_W = 7;

    // ----------------------------------------------------------------
    // Status flag bit positions
    // ----------------------------------------------------------------
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;
    localparam int HALF_BIT = 3;

    // ----------------------------------------------------------------
    // Program counter steps and cycle counts
    // ----------------------------------------------------------------
    localparam logic [PC_W-1:0] PC_STEP_ONE = 16'h0001;
    localparam logic [PC_W-1:0] PC_STEP_SKIP1 = 16'h0002;
    localparam logic [PC_W-1:0] PC_STEP_SKIP2 = 16'h0003;
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] FLAGS_RESET = 8'h00;

    // ----------------------------------------------------------------
    // Operations handled by this unit
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        NOP_OP = 5'h00,
        COMPARE_SKIP_EQUAL_OP = 5'h01,
        COMPARE_IMMEDIATE_OP = 5'h02,
        SKIP_REG_BIT_CLEAR_OP = 5'h03,
        SKIP_REG_BIT_SET_OP = 5'h04,
        SKIP_IO_BIT_CLEAR_OP = 5'h05,
        SKIP_IO_BIT_SET_OP = 5'h06,
        BRANCH_FLAG_SET_OP = 5'h07,
        BRANCH_FLAG_CLEAR_OP = 5'h08,
        BRANCH_EQUAL_OP = 5'h09,
        BRANCH_NOT_EQUAL_OP = 5'h0a,
        BRANCH_CARRY_SET_OP = 5'h0b,
        BRANCH_CARRY_CLEAR_OP = 5'h0c,
        BRANCH_SAME_HIGHER_OP = 5'h0d,
        BRANCH_LOWER_OP = 5'h0e,
        BRANCH_MINUS_OP = 5'h0f,
        BRANCH_PLUS_OP = 5'h10,
        BRANCH_SIGNED_GE_OP = 5'h11,
        BRANCH_SIGNED_LT_OP = 5'h12,
        BRANCH_HALFCARRY_SET_OP = 5'h13,
        BRANCH_HALFCARRY_CLEAR_OP = 5'h14,
        BRANCH_TRANSFER_BIT_SET_OP = 5'h15,
        BRANCH_TRANSFER_BIT_CLEAR_OP = 5'h16,
        BRANCH_OVERFLOW_SET_OP = 5'h17,
        BRANCH_OVERFLOW_CLEAR_OP = 5'h18
    } op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT1 = 2'b01,
        ST_WAIT2 = 2'b11
    } state_t;

    // Decoded instruction as handed over by the decoder
    typedef struct packed {
        op_t op;
        logic [DATA_W-1:0] rd_val;
        logic [DATA_W-1:0] rr_val;
        logic [DATA_W-1:0] imm;
        logic [2:0] bit_sel;
        logic [OFS_W-1:0] offset;
        logic next_two_words;
    } instr_t;

    // Result back to the core
    typedef struct packed {
        logic [PC_W-1:0] pc;
        logic [DATA_W-1:0] flags;
        logic [1:0] cycles;
        logic taken;
    } result_t;

endpackage : cmp_branch_pkg

// ===== core/compare_skip_branch_unit.sv
// How it works
// - Equal-compare of two registers skips the next instruction; 1, 2 or 3 cycles, flags kept.
// - Compare with immediate subtracts, stores nothing, updates Z N V S C H in one cycle.
// - Skip next instruction when selected register bit is zero; 1, 2 or 3 cycles.
// - Skip next instruction when selected register bit is one; 1, 2 or 3 cycles.
// - Skip next instruction when selected I/O bit is zero; 1, 2 or 3 cycles.
// - Skip next instruction when selected I/O bit is one; 1, 2 or 3 cycles.
// - Branch to pc plus offset plus one when indexed flag is one.
// - Branch to pc plus offset plus one when indexed flag is zero.
// - Branch when zero flag is one, else continue in sequence.
// - Branch when zero flag is zero, else fall through.
// - Carry-set and lower branches both jump when carry is one.
// - Carry-clear and same-or-higher branches both jump when carry is zero.
// - Minus branches on negative one; plus branches on negative zero.
// - Signed greater-or-equal branches when negative xor overflow is zero.
// - Signed less-than branches when negative xor overflow is one.
// - Half-carry branches jump on flag one (set) or zero (clear).
// - Transfer-bit branches jump on T one (set) or zero (clear).
// - Overflow branches jump on V zero (clear) or one (set).
`timescale 1ns/1ps
module compare_skip_branch_unit (
    input wire logic CLK,
    input wire logic RST,
    input wire logic ISSUE,
    input wire cmp_branch_pkg::instr_t INSTR,
    input wire logic [cmp_branch_pkg::PC_W-1:0] PC_IN,
    input wire logic [cmp_branch_pkg::DATA_W-1:0] IO_VAL,
    output logic BUSY,
    output logic DONE,
    output cmp_branch_pkg::result_t RESULT
);
    import cmp_branch_pkg::*;

    // ----------------------------------------------------------------
    // Decode of condition
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] flags_q;
    logic cond;
    logic is_skip;
    logic is_branch;
    logic [DATA_W:0] diff;
    logic [DATA_W-1:0] cmp_flags;
    logic n_x_v;

    assign n_x_v = flags_q[FLAG_N] ^ flags_q[FLAG_V];

    always_comb begin
        cond = 1'b0;
        is_skip = 1'b0;
        is_branch = 1'b1;
        case (INSTR.op)
            COMPARE_SKIP_EQUAL_OP: begin
                is_skip = 1'b1;
                is_branch = 1'b0;
                cond = (INSTR.rd_val == INSTR.rr_val);
            end
            SKIP_REG_BIT_CLEAR_OP: begin
                is_skip = 1'b1;
                is_branch = 1'b0;
                cond = ~INSTR.rr_val[INSTR.bit_sel];
            end
            SKIP_REG_BIT_SET_OP: begin
                is_skip = 1'b1;
                is_branch = 1'b0;
                cond = INSTR.rr_val[INSTR.bit_sel];
            end
            SKIP_IO_BIT_CLEAR_OP: begin
                is_skip = 1'b1;
                is_branch = 1'b0;
                cond = ~IO_VAL[INSTR.bit_sel];
            end
            SKIP_IO_BIT_SET_OP: begin
                is_skip = 1'b1;
                is_branch = 1'b0;
                cond = IO_VAL[INSTR.bit_sel];
            end
            BRANCH_FLAG_SET_OP: cond = flags_q[INSTR.bit_sel];
            BRANCH_FLAG_CLEAR_OP: cond = ~flags_q[INSTR.bit_sel];
            BRANCH_EQUAL_OP: cond = flags_q[FLAG_Z];
            BRANCH_NOT_EQUAL_OP: cond = ~flags_q[FLAG_Z];
            BRANCH_CARRY_SET_OP, BRANCH_LOWER_OP: cond = flags_q[FLAG_C];
            BRANCH_CARRY_CLEAR_OP, BRANCH_SAME_HIGHER_OP: cond = ~flags_q[FLAG_C];
            BRANCH_MINUS_OP: cond = flags_q[FLAG_N];
            BRANCH_PLUS_OP: cond = ~flags_q[FLAG_N];
            BRANCH_SIGNED_GE_OP: cond = ~n_x_v;
            BRANCH_SIGNED_LT_OP: cond = n_x_v;
            BRANCH_HALFCARRY_SET_OP: cond = flags_q[FLAG_H];
            BRANCH_HALFCARRY_CLEAR_OP: cond = ~flags_q[FLAG_H];
            BRANCH_TRANSFER_BIT_SET_OP: cond = flags_q[FLAG_T];
            BRANCH_TRANSFER_BIT_CLEAR_OP: cond = ~flags_q[FLAG_T];
            BRANCH_OVERFLOW_SET_OP: cond = flags_q[FLAG_V];
            BRANCH_OVERFLOW_CLEAR_OP: cond = ~flags_q[FLAG_V];
            default: is_branch = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Compare arithmetic
    // ----------------------------------------------------------------
    assign diff = {1'b0, INSTR.rd_val} - {1'b0, INSTR.imm};

    always_comb begin
        cmp_flags = flags_q;
        cmp_flags[FLAG_Z] = (diff[DATA_W-1:0] == '0);
        cmp_flags[FLAG_N] = diff[DATA_W-1];
        cmp_flags[FLAG_C] = diff[DATA_W];
        cmp_flags[FLAG_V] = (INSTR.rd_val[DATA_W-1] & ~INSTR.imm[DATA_W-1] & ~diff[DATA_W-1])
            | (~INSTR.rd_val[DATA_W-1] & INSTR.imm[DATA_W-1] & diff[DATA_W-1]);
        cmp_flags[FLAG_S] = diff[DATA_W-1] ^ cmp_flags[FLAG_V];
        cmp_flags[FLAG_H] = (~INSTR.rd_val[HALF_BIT] & INSTR.imm[HALF_BIT])
            | (INSTR.imm[HALF_BIT] & diff[HALF_BIT]) | (diff[HALF_BIT] & ~INSTR.rd_val[HALF_BIT]);
    end

    // ----------------------------------------------------------------
    // Next pc, cycle count
    // ----------------------------------------------------------------
    logic [PC_W-1:0] pc_next;
    logic [1:0] cyc_next;
    logic [PC_W-1:0] ofs_ext;

    // Sign extension of the branch offset
    assign ofs_ext = {{(PC_W-OFS_W){INSTR.offset[OFS_W-1]}}, INSTR.offset};

    always_comb begin
        pc_next = PC_IN + PC_STEP_ONE;
        cyc_next = CYC_ONE;
        if (is_skip && cond) begin
            pc_next = PC_IN + (INSTR.next_two_words ? PC_STEP_SKIP2 : PC_STEP_SKIP1);
            cyc_next = INSTR.next_two_words ? CYC_THREE : CYC_TWO;
        end else if (is_branch && cond) begin
            pc_next = PC_IN + ofs_ext + PC_STEP_ONE;
            cyc_next = CYC_TWO;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer: holds BUSY for the extra cycles of a multi-cycle result
    // ----------------------------------------------------------------
    state_t state_q;
    logic accept;

    assign accept = ISSUE && (state_q == ST_IDLE);
    assign BUSY = (state_q != ST_IDLE);

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (accept && cyc_next == CYC_THREE) begin
                        state_q <= ST_WAIT2;
                    end else if (accept && cyc_next == CYC_TWO) begin
                        state_q <= ST_WAIT1;
                    end
                end
                ST_WAIT2: state_q <= ST_WAIT1;
                ST_WAIT1: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Status flags: only a compare with immediate writes them
    // ----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            flags_q <= FLAGS_RESET;
        end else if (accept && INSTR.op == COMPARE_IMMEDIATE_OP) begin
            flags_q <= cmp_flags;
        end
    end

    // ----------------------------------------------------------------
    // Result register
    // ----------------------------------------------------------------
    logic done_q;
    assign DONE = done_q;

    always_ff @(posedge CLK) begin
        if (RST) begin
            RESULT <= '{pc: PC_RESET, flags: FLAGS_RESET, cycles: CYC_ONE, taken: 1'b0};
            done_q <= 1'b0;
        end else begin
            done_q <= accept;
            if (accept) begin
                RESULT.pc <= pc_next;
                RESULT.cycles <= cyc_next;
                RESULT.taken <= cond && (is_skip || is_branch);
                RESULT.flags <= (INSTR.op == COMPARE_IMMEDIATE_OP) ? cmp_flags : flags_q;
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_skip_taken;
        accept && is_skip && cond;
    endsequence

    property p_skip_pc;
        @(posedge CLK) disable iff (RST)
        s_skip_taken |=> (RESULT.pc == $past(PC_IN) + ($past(INSTR.next_two_words) ? 16'h0003 : 16'h0002));
    endproperty
    a_skip_pc: assert property (p_skip_pc) else $error("skip pc wrong");

    property p_skip_busy;
        @(posedge CLK) disable iff (RST)
        (s_skip_taken and INSTR.next_two_words) |=> BUSY [*2] ##1 !BUSY;
    endproperty
    a_skip_busy: assert property (p_skip_busy) else $error("skip busy length wrong");

    property p_branch_taken;
        @(posedge CLK) disable iff (RST)
        (accept && is_branch && cond) |=> RESULT.pc == $past(PC_IN) + $past(ofs_ext) + 16'h0001
            && RESULT.cycles == 2'h2 && BUSY ##1 !BUSY;
    endproperty
    a_branch_taken: assert property (p_branch_taken) else $error("taken branch wrong");

    property p_untaken;
        @(posedge CLK) disable iff (RST)
        (accept && !cond) |=> RESULT.pc == $past(PC_IN) + 16'h0001 && !BUSY && RESULT.cycles == 2'h1;
    endproperty
    a_untaken: assert property (p_untaken) else $error("fall through wrong");

    property p_flags_kept;
        @(posedge CLK) disable iff (RST)
        (accept && INSTR.op != COMPARE_IMMEDIATE_OP) |=> $stable(flags_q);
    endproperty
    a_flags_kept: assert property (p_flags_kept) else $error("flags changed");

    property p_cmp_zero;
        @(posedge CLK) disable iff (RST)
        (accept && INSTR.op == COMPARE_IMMEDIATE_OP) |=> flags_q[1] == ($past(INSTR.rd_val) == $past(INSTR.imm))
            && flags_q[0] == ($past(INSTR.rd_val) < $past(INSTR.imm)) && !BUSY;
    endproperty
    a_cmp_zero: assert property (p_cmp_zero) else $error("compare flags wrong");

    property p_beq;
        @(posedge CLK) disable iff (RST)
        (accept && INSTR.op == BRANCH_EQUAL_OP) |=> RESULT.taken == $past(flags_q[1]);
    endproperty
    a_beq: assert property (p_beq) else $error("equal branch wrong");

    property p_bne;
        @(posedge CLK) disable iff (RST)
        (accept && INSTR.op == BRANCH_NOT_EQUAL_OP) |=> RESULT.taken != $past(flags_q[1]);
    endproperty
    a_bne: assert property (p_bne) else $error("not equal branch wrong");

    property p_lt;
        @(posedge CLK) disable iff (RST)
        (accept && INSTR.op == BRANCH_SIGNED_LT_OP) |=> RESULT.taken == ($past(flags_q[2]) ^ $past(flags_q[3]));
    endproperty
    a_lt: assert property (p_lt) else $error("signed less branch wrong");

    property p_done;
        @(posedge CLK) disable iff (RST)
        accept |=> DONE;
    endproperty
    a_done: assert property (p_done) else $error("done missing");

    property p_skip_short;
        @(posedge CLK) disable iff (RST)
        (s_skip_taken and !INSTR.next_two_words) |=> BUSY ##1 !BUSY;
    endproperty
    a_skip_short: assert property (p_skip_short) else $error("short skip busy length wrong");

    property p_cmp_single;
        @(posedge CLK) disable iff (RST)
        (accept && INSTR.op == COMPARE_IMMEDIATE_OP) |=> RESULT.cycles == CYC_ONE && !RESULT.taken && !BUSY;
    endproperty
    a_cmp_single: assert property (p_cmp_single) else $error("compare not single cycle");

    // Requests that arrive while busy must leave no trace in the result
    property p_refused;
        @(posedge CLK) disable iff (RST)
        (ISSUE && BUSY) |=> !DONE;
    endproperty
    a_refused: assert property (p_refused) else $error("request taken while busy");

    property p_ge;
        @(posedge CLK) disable iff (RST)
        (accept && INSTR.op == BRANCH_SIGNED_GE_OP)
            |=> RESULT.taken == !($past(flags_q[FLAG_N]) ^ $past(flags_q[FLAG_V]));
    endproperty
    a_ge: assert property (p_ge) else $error("signed greater or equal branch wrong");

    property p_carry_set;
        @(posedge CLK) disable iff (RST)
        (accept && (INSTR.op == BRANCH_CARRY_SET_OP || INSTR.op == BRANCH_LOWER_OP))
            |=> RESULT.taken == $past(flags_q[FLAG_C]);
    endproperty
    a_carry_set: assert property (p_carry_set) else $error("carry set branch wrong");

    property p_flag_set;
        @(posedge CLK) disable iff (RST)
        (accept && INSTR.op == BRANCH_FLAG_SET_OP) |=> RESULT.taken == $past(flags_q[INSTR.bit_sel]);
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("indexed flag branch wrong");

    property p_io_clear;
        @(posedge CLK) disable iff (RST)
        (accept && INSTR.op == SKIP_IO_BIT_CLEAR_OP) |=> RESULT.taken == !$past(IO_VAL[INSTR.bit_sel]);
    endproperty
    a_io_clear: assert property (p_io_clear) else $error("io bit clear skip wrong");

endmodule : compare_skip_branch_unit

// ===== bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import cmp_branch_pkg::*;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic ISSUE = 1'b0;
    instr_t INSTR = '0;
    logic [PC_W-1:0] PC_IN = '0;
    logic [DATA_W-1:0] IO_VAL = '0;
    logic BUSY;
    logic DONE;
    result_t RESULT;
    int n_mismatch = 0;
    int total_checks = 0;
    int seed = 21783;
    int cycle_count = 0;
    logic [DATA_W-1:0] mflags = FLAGS_RESET;
    instr_t a;
    instr_t b;

    always #25 CLK = ~CLK;

    compare_skip_branch_unit dut (
        .CLK(CLK),
        .RST(RST),
        .ISSUE(ISSUE),
        .INSTR(INSTR),
        .PC_IN(PC_IN),
        .IO_VAL(IO_VAL),
        .BUSY(BUSY),
        .DONE(DONE),
        .RESULT(RESULT)
    );

    // ----------------------------------------------------------------
    // Reporting
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] expected, input string what);
        total_checks++;
        if (seen !== expected) begin
            n_mismatch++;
            $display("mismatch at %0t: %s seen %0h expected %0h", $time, what, seen, expected);
        end
    endtask : check

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    // Bound well above the ~4400 cycles the sequence needs
    always @(posedge CLK) begin
        cycle_count <= cycle_count + 1;
        if (cycle_count == 30000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    // ----------------------------------------------------------------
    // Reference model and one issued instruction
    // ----------------------------------------------------------------
    task automatic run(input instr_t i, input logic [15:0] pc, input logic [7:0] io);
        logic sk;
        logic br;
        logic is_br;
        logic is_sk;
        logic [15:0] epc;
        logic [1:0] ecyc;
        logic [7:0] f;
        logic [7:0] r;
        int n;
        f = mflags;
        sk = 1'b0;
        br = 1'b0;
        epc = pc + 16'h0001;
        ecyc = CYC_ONE;
        is_br = (i.op >= BRANCH_FLAG_SET_OP);
        is_sk = (i.op >= COMPARE_SKIP_EQUAL_OP) && (i.op <= SKIP_IO_BIT_SET_OP) && (i.op != COMPARE_IMMEDIATE_OP);
        case (i.op)
            COMPARE_SKIP_EQUAL_OP: sk = (i.rd_val == i.rr_val);
            COMPARE_IMMEDIATE_OP: begin
                r = i.rd_val - i.imm;
                f[FLAG_C] = i.rd_val < i.imm;
                f[FLAG_Z] = (r == 8'h00);
                f[FLAG_N] = r[7];
                f[FLAG_V] = (i.rd_val[7] & ~i.imm[7] & ~r[7]) | (~i.rd_val[7] & i.imm[7] & r[7]);
                f[FLAG_S] = f[FLAG_N] ^ f[FLAG_V];
                f[FLAG_H] = (~i.rd_val[3] & i.imm[3]) | (i.imm[3] & r[3]) | (r[3] & ~i.rd_val[3]);
            end
            SKIP_REG_BIT_CLEAR_OP: sk = ~i.rr_val[i.bit_sel];
            SKIP_REG_BIT_SET_OP: sk = i.rr_val[i.bit_sel];
            SKIP_IO_BIT_CLEAR_OP: sk = ~io[i.bit_sel];
            SKIP_IO_BIT_SET_OP: sk = io[i.bit_sel];
            BRANCH_FLAG_SET_OP: br = f[i.bit_sel];
            BRANCH_FLAG_CLEAR_OP: br = ~f[i.bit_sel];
            BRANCH_EQUAL_OP: br = f[FLAG_Z];
            BRANCH_NOT_EQUAL_OP: br = ~f[FLAG_Z];
            BRANCH_CARRY_SET_OP, BRANCH_LOWER_OP: br = f[FLAG_C];
            BRANCH_CARRY_CLEAR_OP, BRANCH_SAME_HIGHER_OP: br = ~f[FLAG_C];
            BRANCH_MINUS_OP: br = f[FLAG_N];
            BRANCH_PLUS_OP: br = ~f[FLAG_N];
            BRANCH_SIGNED_GE_OP: br = ~(f[FLAG_N] ^ f[FLAG_V]);
            BRANCH_SIGNED_LT_OP: br = f[FLAG_N] ^ f[FLAG_V];
            BRANCH_HALFCARRY_SET_OP: br = f[FLAG_H];
            BRANCH_HALFCARRY_CLEAR_OP: br = ~f[FLAG_H];
            BRANCH_TRANSFER_BIT_SET_OP: br = f[FLAG_T];
            BRANCH_TRANSFER_BIT_CLEAR_OP: br = ~f[FLAG_T];
            BRANCH_OVERFLOW_SET_OP: br = f[FLAG_V];
            BRANCH_OVERFLOW_CLEAR_OP: br = ~f[FLAG_V];
            default: br = 1'b0;
        endcase
        if (sk) begin
            epc = pc + (i.next_two_words ? PC_STEP_SKIP2 : PC_STEP_SKIP1);
            ecyc = i.next_two_words ? CYC_THREE : CYC_TWO;
        end
        if (br) begin
            epc = pc + {{9{i.offset[6]}}, i.offset} + 16'h0001;
            ecyc = CYC_TWO;
        end
        @(posedge CLK);
        ISSUE <= 1'b1;
        INSTR <= i;
        PC_IN <= pc;
        IO_VAL <= io;
        @(posedge CLK);
        ISSUE <= 1'b0;
        #1;
        check({31'h0, DONE}, 32'h1, "done");
        if (is_sk) begin
            check({16'h0, RESULT.pc}, {16'h0, epc}, "skip pc");
            check({30'h0, RESULT.cycles}, {30'h0, ecyc}, "skip cycles");
        end else begin
            check({16'h0, RESULT.pc}, {16'h0, epc}, "pc");
            check({30'h0, RESULT.cycles}, {30'h0, ecyc}, "cycles");
        end
        if (is_br) begin
            check({31'h0, RESULT.taken}, {31'h0, br}, "taken");
        end else begin
            check({31'h0, RESULT.taken}, {31'h0, sk}, "skip taken");
        end
        if (i.op == COMPARE_IMMEDIATE_OP) begin
            check({24'h0, RESULT.flags}, {24'h0, f}, "compare flags");
        end else begin
            check({24'h0, RESULT.flags}, {24'h0, f}, "flags kept");
        end
        n = 0;
        while (BUSY === 1'b1 && n < 4) begin
            @(posedge CLK);
            #1;
            n++;
        end
        check(n, ecyc - 1, "busy length");
        mflags = f;
    endtask : run

    task automatic rnd(input op_t op);
        instr_t i;
        logic [31:0] rv;
        logic [31:0] rw;
        rv = $random(seed);
        rw = $random(seed);
        i.op = op;
        i.rd_val = rv[7:0];
        i.imm = (rv[29] & rv[30]) ? rv[7:0] : rv[15:8];
        i.rr_val = rv[28] ? rv[7:0] : rv[23:16];
        i.bit_sel = rv[26:24];
        i.next_two_words = rv[27];
        i.offset = rw[30:24];
        run(i, rw[15:0], rw[23:16]);
    endtask : rnd

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(posedge CLK);
        RST <= 1'b0;
        for (int k = 0; k < 40; k++) begin
            for (int o = 1; o <= 24; o++) begin
                rnd(COMPARE_IMMEDIATE_OP);
                rnd(op_t'(o[4:0]));
            end
        end
        // Request held through a three-cycle skip is ignored until idle
        a = '0;
        a.op = SKIP_IO_BIT_SET_OP;
        a.bit_sel = 3'h7;
        a.next_two_words = 1'b1;
        b = '0;
        b.op = COMPARE_IMMEDIATE_OP;
        b.imm = 8'h01;
        @(posedge CLK);
        ISSUE <= 1'b1;
        INSTR <= a;
        PC_IN <= 16'h0100;
        IO_VAL <= 8'hff;
        @(posedge CLK);
        INSTR <= b;
        #1;
        check({16'h0, RESULT.pc}, 32'h0103, "io skip pc");
        repeat (2) begin
            @(posedge CLK);
            #1;
            check({31'h0, DONE}, 32'h0, "refused");
        end
        @(posedge CLK);
        ISSUE <= 1'b0;
        #1;
        check({31'h0, DONE}, 32'h1, "late accept");
        check({24'h0, RESULT.flags}, {24'h0, mflags[7:6], 6'h35}, "borrow flags");
        mflags = {mflags[7:6], 6'h35};
        // Second reset in mid-run clears the held flags
        @(posedge CLK);
        RST <= 1'b1;
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        #1;
        check({31'h0, DONE}, 32'h0, "reset done");
        check({16'h0, RESULT.pc}, 32'h0, "reset pc");
        mflags = FLAGS_RESET;
        for (int o = 7; o <= 24; o++) begin
            rnd(op_t'(o[4:0]));
        end
        end_of_test();
    end
endmodule : testbench
